// *** rtl/sadc_pkg.sv ***
// Package for the converter sequencer: register map, field positions,
// reset values and timing constants.
// Assumes a 32-bit APB slave with one aligned word per register.
package sadc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CONTROL_MAIN = 12'h000;
    localparam logic [11:0] OFS_PORT_REF = 12'h004;
    localparam logic [11:0] OFS_TIMING_FMT = 12'h008;
    localparam logic [11:0] OFS_RESULT_HIGH = 12'h00c;
    localparam logic [11:0] OFS_RESULT_LOW = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_CONVERTER_ON = 0;
    localparam int BIT_GO = 1;
    localparam int POS_CHANNEL = 2;
    localparam int BIT_CALIBRATE = 7;
    localparam int POS_PORT_CFG = 0;
    localparam int BIT_VREF_POS = 4;
    localparam int BIT_VREF_NEG = 5;
    localparam int POS_CLK_SEL = 0;
    localparam int POS_ACQ = 3;
    localparam int BIT_JUSTIFY = 7;
    localparam int BIT_DONE_FLAG = 0;

    // Writable masks; unimplemented bits read as zero
    localparam logic [7:0] MASK_CONTROL_MAIN = 8'hbf;
    localparam logic [7:0] MASK_PORT_REF = 8'h3f;
    localparam logic [7:0] MASK_TIMING_FMT = 8'hbf;
    localparam logic [7:0] RESET_CONTROL = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int RESULT_BITS = 10;
    localparam int CONV_PERIODS = 11;
    localparam int GAP_PERIODS = 2;
    localparam int CLK_HZ = 25000000;
    localparam int RC_PERIOD_NS = 4000;
    localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
    localparam int RC_HALF_CYCLES = (RC_PERIOD_NS / 2) / CLK_PERIOD_NS;
    // One instruction cycle is four oscillator periods
    localparam int INSTR_CYCLES = 4;

    typedef enum logic [2:0] {
        SADC_IDLE,
        SADC_RC_DELAY,
        SADC_ACQUIRE,
        SADC_CONVERT,
        SADC_GAP
    } sadc_state_t;

endpackage

// *** rtl/sadc_tick_gen.sv ***
// Bit-period tick generator for the converter sequencer.
// Assumes pclk is the system oscillator; the RC source is modelled by a
// free counter on pclk with the typical RC period.
`timescale 1ns/1ps

module sadc_tick_gen
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [2:0] clk_sel,
    output logic tick
);

    logic [9:0] count;
    logic [9:0] terminal;

    always_comb
    begin
        case (clk_sel)
            3'h0: terminal = 10'h001;
            3'h4: terminal = 10'h003;
            3'h1: terminal = 10'h007;
            3'h5: terminal = 10'h00f;
            3'h2: terminal = 10'h01f;
            3'h6: terminal = 10'h03f;
            default: terminal = 10'((2 * sadc_pkg::RC_HALF_CYCLES) - 1);
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= 10'h000;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            count <= 10'h000;
            tick <= 1'b0;
        end
        else if (count >= terminal)
        begin
            count <= 10'h000;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 10'h001;
            tick <= 1'b0;
        end
    end

endmodule

// *** rtl/sadc_sequencer.sv ***
// Sequencer for a 10-bit successive-approximation converter with APB
// registers, acquisition timer, clock select and result formatting.
// Assumes the analog comparator answers cmp_high within one bit period.
`timescale 1ns/1ps

module sadc_sequencer #(
    parameter int NUM_INPUTS = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_req,
    input wire logic cmp_high,
    output logic [3:0] mux_channel,
    output logic sample_on,
    output logic [9:0] dac_code,
    output logic calibrate_on,
    output logic vref_neg_ext,
    output logic vref_pos_ext,
    output logic [15:0] analog_in_en,
    output logic conversion_done_flag
);

    logic [7:0] control_main;
    logic [7:0] port_ref;
    logic [7:0] timing_fmt;
    logic [7:0] result_high;
    logic [7:0] result_low;
    logic done_flag;
    sadc_pkg::sadc_state_t state;
    logic [9:0] sar;
    logic [4:0] period_cnt;
    logic [2:0] rc_cnt;
    logic tick;
    logic run;
    logic rc_sel;
    logic [4:0] acq_periods;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic go_set;
    logic go_clr;
    logic finish;
    logic [9:0] final_code;
    logic [15:0] next_analog;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign rc_sel = timing_fmt[sadc_pkg::POS_CLK_SEL +: 2] == 2'b11;

    // in sleep only the RC source keeps ticking
    assign run = control_main[sadc_pkg::BIT_CONVERTER_ON] && (state != sadc_pkg::SADC_IDLE)
        && (state != sadc_pkg::SADC_RC_DELAY) && (!sleep_req || rc_sel);

    sadc_tick_gen u_tick
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .clk_sel(timing_fmt[sadc_pkg::POS_CLK_SEL +: 3]),
        .tick(tick)
    );

    always_comb
    begin
        case (paddr)
            sadc_pkg::OFS_CONTROL_MAIN,
            sadc_pkg::OFS_PORT_REF,
            sadc_pkg::OFS_TIMING_FMT,
            sadc_pkg::OFS_RESULT_HIGH,
            sadc_pkg::OFS_RESULT_LOW,
            sadc_pkg::OFS_STATUS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        case (timing_fmt[sadc_pkg::POS_ACQ +: 3])
            3'h0: acq_periods = 5'd0;
            3'h1: acq_periods = 5'd2;
            3'h2: acq_periods = 5'd4;
            3'h3: acq_periods = 5'd6;
            3'h4: acq_periods = 5'd8;
            3'h5: acq_periods = 5'd12;
            3'h6: acq_periods = 5'd16;
            default: acq_periods = 5'd20;
        endcase
    end

    assign go_set = wr_en && (paddr == sadc_pkg::OFS_CONTROL_MAIN) && pwdata[sadc_pkg::BIT_GO]
        && !control_main[sadc_pkg::BIT_GO] && control_main[sadc_pkg::BIT_CONVERTER_ON]
        && (state == sadc_pkg::SADC_IDLE);
    assign go_clr = wr_en && (paddr == sadc_pkg::OFS_CONTROL_MAIN) && !pwdata[sadc_pkg::BIT_GO];
    assign finish = (state == sadc_pkg::SADC_CONVERT) && tick
        && (period_cnt == 5'(sadc_pkg::CONV_PERIODS - 1));

    // final trial bit resolved at finish
    always_comb
    begin
        final_code = sar;
        if (!cmp_high)
        begin
            final_code[0] = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // unimplemented bits masked off
    // reset returns all controls to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_main <= sadc_pkg::RESET_CONTROL;
            port_ref <= sadc_pkg::RESET_CONTROL;
            timing_fmt <= sadc_pkg::RESET_CONTROL;
        end
        else
        begin
            if (wr_en && paddr == sadc_pkg::OFS_CONTROL_MAIN)
            begin
                control_main <= pwdata[7:0] & sadc_pkg::MASK_CONTROL_MAIN;
                control_main[sadc_pkg::BIT_GO] <= go_set || (control_main[sadc_pkg::BIT_GO]
                    && pwdata[sadc_pkg::BIT_GO] && pwdata[sadc_pkg::BIT_CONVERTER_ON]);
            end
            else if (finish || !control_main[sadc_pkg::BIT_CONVERTER_ON])
            begin
                control_main[sadc_pkg::BIT_GO] <= 1'b0;
            end
            // calibration request consumed by the conversion
            if (finish)
            begin
                control_main[sadc_pkg::BIT_CALIBRATE] <= 1'b0;
            end
            if (wr_en && paddr == sadc_pkg::OFS_PORT_REF)
            begin
                port_ref <= pwdata[7:0] & sadc_pkg::MASK_PORT_REF;
            end
            if (wr_en && paddr == sadc_pkg::OFS_TIMING_FMT)
            begin
                timing_fmt <= pwdata[7:0] & sadc_pkg::MASK_TIMING_FMT;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= sadc_pkg::SADC_IDLE;
            period_cnt <= 5'd0;
            rc_cnt <= 3'd0;
            sar <= 10'h000;
        end
        else if (!control_main[sadc_pkg::BIT_CONVERTER_ON] || (go_clr && state != sadc_pkg::SADC_GAP
            && state != sadc_pkg::SADC_IDLE))
        begin
            state <= control_main[sadc_pkg::BIT_CONVERTER_ON] ? sadc_pkg::SADC_GAP : sadc_pkg::SADC_IDLE;
            period_cnt <= 5'd0;
            sar <= 10'h000;
        end
        else
        begin
            case (state)
                sadc_pkg::SADC_IDLE:
                begin
                    if (go_set)
                    begin
                        if (rc_sel)
                        begin
                            state <= sadc_pkg::SADC_RC_DELAY;
                        end
                        else if (acq_periods != 5'd0)
                        begin
                            state <= sadc_pkg::SADC_ACQUIRE;
                        end
                        else
                        begin
                            state <= sadc_pkg::SADC_CONVERT;
                            sar <= 10'h200;
                        end
                        rc_cnt <= 3'd0;
                        period_cnt <= 5'd0;
                    end
                end
                sadc_pkg::SADC_RC_DELAY:
                begin
                    if (rc_cnt == 3'(sadc_pkg::INSTR_CYCLES - 1))
                    begin
                        state <= (acq_periods != 5'd0) ? sadc_pkg::SADC_ACQUIRE : sadc_pkg::SADC_CONVERT;
                        sar <= 10'h200;
                    end
                    rc_cnt <= rc_cnt + 3'd1;
                end
                sadc_pkg::SADC_ACQUIRE:
                begin
                    if (tick)
                    begin
                        if (period_cnt == acq_periods - 5'd1)
                        begin
                            state <= sadc_pkg::SADC_CONVERT;
                            period_cnt <= 5'd0;
                            sar <= 10'h200;
                        end
                        else
                        begin
                            period_cnt <= period_cnt + 5'd1;
                        end
                    end
                end
                sadc_pkg::SADC_CONVERT:
                begin
                    if (tick)
                    begin
                        if (finish)
                        begin
                            state <= sadc_pkg::SADC_GAP;
                            period_cnt <= 5'd0;
                        end
                        else
                        begin
                            if (period_cnt >= 5'd1 && period_cnt <= 5'd9)
                            begin
                                sar[10 - period_cnt] <= cmp_high;
                                sar[9 - period_cnt] <= 1'b1;
                            end
                            period_cnt <= period_cnt + 5'd1;
                        end
                    end
                end
                sadc_pkg::SADC_GAP:
                begin
                    if (tick)
                    begin
                        if (period_cnt == 5'(sadc_pkg::GAP_PERIODS - 1))
                        begin
                            state <= sadc_pkg::SADC_IDLE;
                        end
                        period_cnt <= period_cnt + 5'd1;
                    end
                end
                default:
                begin
                    state <= sadc_pkg::SADC_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Result pair and done flag
    // ------------------------------------------------------------------
    // result pair is not reset, so it holds its old contents
    always_ff @(posedge pclk)
    begin
        if (finish)
        begin
            if (timing_fmt[sadc_pkg::BIT_JUSTIFY])
            begin
                result_high <= {6'h00, final_code[9:8]};
                result_low <= final_code[7:0];
            end
            else
            begin
                result_high <= final_code[9:2];
                result_low <= {final_code[1:0], 6'h00};
            end
        end
        else if (wr_en && paddr == sadc_pkg::OFS_RESULT_HIGH)
        begin
            result_high <= pwdata[7:0];
        end
        else if (wr_en && paddr == sadc_pkg::OFS_RESULT_LOW)
        begin
            result_low <= pwdata[7:0];
        end
    end

    // Set wins over a simultaneous software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_flag <= 1'b0;
        end
        else if (finish)
        begin
            done_flag <= 1'b1;
        end
        else if (wr_en && paddr == sadc_pkg::OFS_STATUS && pwdata[sadc_pkg::BIT_DONE_FLAG])
        begin
            done_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Analog controls
    // ------------------------------------------------------------------
    // top-down digital selection per input
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_pin
            // Code zero keeps all analog; code k turns the top k+1 inputs digital
            assign next_analog[gi] = (gi < NUM_INPUTS)
                && (port_ref[sadc_pkg::POS_PORT_CFG +: 4] == 4'h0
                || gi < 15 - int'(port_ref[sadc_pkg::POS_PORT_CFG +: 4]));
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mux_channel <= 4'h0;
            sample_on <= 1'b0;
            dac_code <= 10'h000;
            calibrate_on <= 1'b0;
            vref_neg_ext <= 1'b0;
            vref_pos_ext <= 1'b0;
            analog_in_en <= 16'h0000;
            conversion_done_flag <= 1'b0;
        end
        else
        begin
            mux_channel <= control_main[sadc_pkg::POS_CHANNEL +: 4];
            sample_on <= control_main[sadc_pkg::BIT_CONVERTER_ON]
                && (state == sadc_pkg::SADC_IDLE || state == sadc_pkg::SADC_ACQUIRE
                || state == sadc_pkg::SADC_RC_DELAY);
            // ten-bit trial code to the DAC
            dac_code <= sar;
            calibrate_on <= control_main[sadc_pkg::BIT_CALIBRATE] && state == sadc_pkg::SADC_CONVERT;
            vref_neg_ext <= port_ref[sadc_pkg::BIT_VREF_NEG];
            vref_pos_ext <= port_ref[sadc_pkg::BIT_VREF_POS];
            analog_in_en <= next_analog;
            conversion_done_flag <= done_flag;
        end
    end

    // ------------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    sadc_pkg::OFS_CONTROL_MAIN: prdata[7:0] <= control_main;
                    sadc_pkg::OFS_PORT_REF: prdata[7:0] <= port_ref;
                    sadc_pkg::OFS_TIMING_FMT: prdata[7:0] <= timing_fmt;
                    sadc_pkg::OFS_RESULT_HIGH: prdata[7:0] <= result_high;
                    sadc_pkg::OFS_RESULT_LOW: prdata[7:0] <= result_low;
                    sadc_pkg::OFS_STATUS: prdata[0] <= done_flag;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// *** verification/sadc_properties.sv ***
// Port-level checks for the converter sequencer.
// Assumes an APB master that leaves at least one idle edge between transfers.
`timescale 1ns/1ps

module sadc_checker #(
    parameter int NUM_INPUTS = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleep_req,
    input wire logic cmp_high,
    input wire logic [3:0] mux_channel,
    input wire logic sample_on,
    input wire logic [9:0] dac_code,
    input wire logic calibrate_on,
    input wire logic vref_neg_ext,
    input wire logic vref_pos_ext,
    input wire logic [15:0] analog_in_en,
    input wire logic conversion_done_flag
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    logic acc;
    logic [7:0] main_val;
    logic [7:0] ref_val;
    logic [15:0] an_exp;
    assign acc = psel && penable && pready && pwrite;
    // Digital count is code plus one, except that code zero leaves all analog
    assign an_exp = (ref_val[3:0] == 4'h0 ? 16'hffff : 16'hffff >> (ref_val[3:0] + 5'h01))
        & 16'((32'h1 << NUM_INPUTS) - 1);

    // Last written values, compared two edges after the write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            main_val <= 8'h00;
        else if (acc && paddr == sadc_pkg::OFS_CONTROL_MAIN)
            main_val <= pwdata[7:0];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ref_val <= 8'h00;
        else if (acc && paddr == sadc_pkg::OFS_PORT_REF)
            ref_val <= pwdata[7:0];
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready one cycle after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    error_read_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    channel_route_a: assert property (acc && paddr == sadc_pkg::OFS_CONTROL_MAIN |-> ##2 mux_channel == main_val[5:2])
        else $error("channel not routed");
    reference_select_a: assert property (acc && paddr == sadc_pkg::OFS_PORT_REF |-> ##2 {vref_neg_ext, vref_pos_ext} == ref_val[5:4])
        else $error("reference select wrong");
    analog_pins_a: assert property (acc && paddr == sadc_pkg::OFS_PORT_REF |-> ##2 analog_in_en == an_exp)
        else $error("analog pin map wrong");
    calib_no_sample_a: assert property (calibrate_on |-> !sample_on)
        else $error("sampling during calibrated conversion");
    done_sticky_a: assert property ($fell(conversion_done_flag) |-> $past(acc && paddr == sadc_pkg::OFS_STATUS && pwdata[0]) || $past(acc && paddr == sadc_pkg::OFS_STATUS && pwdata[0], 2))
        else $error("done flag cleared without write");
    reset_quiet_a: assert property (@(posedge pclk) disable iff (1'b0) !presetn |-> {mux_channel, dac_code, calibrate_on, sample_on, vref_neg_ext, vref_pos_ext, conversion_done_flag} == 21'h0)
        else $error("outputs active in reset");
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the converter sequencer, driven over APB.
// Assumes the comparator model below stands in for the analog front end.
`timescale 1ns/1ps

module tb_top;
    logic pclk, presetn, psel, penable, pwrite, sleep_req, cmp_high, re, calib_seen, last_j;
    logic pready, pslverr, sample_on, calibrate_on, vref_neg_ext, vref_pos_ext, conversion_done_flag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [3:0] mux_channel;
    logic [9:0] dac_code, target;
    logic [15:0] analog_in_en;
    int fail_count, comparisons, cycles, seed;
    int res_q[$];
    int pertab[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
    int acqtab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

    sadc_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_req(sleep_req), .cmp_high(cmp_high), .mux_channel(mux_channel), .sample_on(sample_on),
        .dac_code(dac_code), .calibrate_on(calibrate_on), .vref_neg_ext(vref_neg_ext),
        .vref_pos_ext(vref_pos_ext), .analog_in_en(analog_in_en), .conversion_done_flag(conversion_done_flag));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Comparator model: high while the held input is at or above the trial
    assign cmp_high = target >= dac_code;

    always @(posedge pclk)
    begin
        calib_seen <= calib_seen | calibrate_on;
        cycles++;
        if (cycles == 60000)
        begin
            fail_count++;
            give_verdict;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, x);
    endtask

    task automatic rd_resets;
        rd(sadc_pkg::OFS_CONTROL_MAIN, 32'h0);
        rd(sadc_pkg::OFS_PORT_REF, 32'h0);
        rd(sadc_pkg::OFS_TIMING_FMT, 32'h0);
        rd(sadc_pkg::OFS_STATUS, 32'h0);
    endtask

    // One conversion; ab aborts it, sl holds the device asleep
    task automatic conv(input int ck, input int aq, input logic ab, input logic sl);
        int per, n, t;
        logic j, cal, rc;
        logic [3:0] ch;
        logic [9:0] r;
        rc = ck % 4 == 3;
        per = rc ? 2 * sadc_pkg::RC_HALF_CYCLES : pertab[ck];
        n = acqtab[aq] + sadc_pkg::CONV_PERIODS;
        // An aborted run leaves the earlier result in the earlier format
        j = ab ? last_j : 1'($urandom);
        last_j = j;
        cal = 1'($urandom);
        ch = 4'($urandom);
        target = 10'($urandom);
        calib_seen = 1'b0;
        sleep_req <= sl;
        wr(sadc_pkg::OFS_TIMING_FMT, {24'h0, j, 1'b0, 3'(aq), 3'(ck)});
        wr(sadc_pkg::OFS_CONTROL_MAIN, {24'h0, cal, 1'b0, ch, 2'b01});
        wr(sadc_pkg::OFS_CONTROL_MAIN, {24'h0, cal, 1'b0, ch, 2'b11});
        rd(sadc_pkg::OFS_CONTROL_MAIN, {24'h0, cal, 1'b0, ch, 2'b11});
        t = 3;
        if (ab)
        begin
            repeat (5 * per) @(posedge pclk);
            wr(sadc_pkg::OFS_CONTROL_MAIN, {24'h0, cal, 1'b0, ch, 2'b01});
        end
        if (sl && !rc)
        begin
            repeat (4 * n * per) @(posedge pclk);
            check(conversion_done_flag, 1'b0);
            sleep_req <= 1'b0;
        end
        while (conversion_done_flag !== 1'b1 && t < 2 * n * per + 20)
        begin
            @(posedge pclk);
            t++;
        end
        if (ab)
            check(conversion_done_flag, 1'b0);
        else
        begin
            res_q.push_back(int'(target));
            if (!sl || rc)
                check(t >= (n - 1) * per && t <= (n + 1) * per + 8, 1'b1);
            check(calib_seen, cal);
        end
        r = 10'(res_q[$]);
        rd(sadc_pkg::OFS_RESULT_HIGH, j ? 32'(r[9:8]) : 32'(r[9:2]));
        rd(sadc_pkg::OFS_RESULT_LOW, j ? 32'(r[7:0]) : 32'({r[1:0], 6'h0}));
        if (per >= 8 && !ab)
        begin
            wr(sadc_pkg::OFS_CONTROL_MAIN, {26'h0, ch, 2'b11});
            rd(sadc_pkg::OFS_CONTROL_MAIN, {26'h0, ch, 2'b01});
        end
        rd(sadc_pkg::OFS_STATUS, 32'(!ab));
        wr(sadc_pkg::OFS_STATUS, 32'h1);
        repeat (2 * per + 4) @(posedge pclk);
        #1;
        check(sample_on, 1'b1);
        check(conversion_done_flag, 1'b0);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, sleep_req, calib_seen, last_j} = 7'h0;
        {paddr, pwdata, target} = 54'h0;
        seed = $urandom(67949);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_resets;
        apb(1'b0, 12'h018, 32'h0, rq, re);
        check(re, 1'b1);
        check(rq, 32'h0);
        // unimplemented bits, go refused while off
        wr(sadc_pkg::OFS_CONTROL_MAIN, 32'hff);
        rd(sadc_pkg::OFS_CONTROL_MAIN, 32'hbd);
        wr(sadc_pkg::OFS_PORT_REF, 32'hff);
        rd(sadc_pkg::OFS_PORT_REF, 32'h3f);
        wr(sadc_pkg::OFS_TIMING_FMT, 32'hff);
        rd(sadc_pkg::OFS_TIMING_FMT, 32'hbf);
        for (int k = 0; k < 16; k++)
        begin
            wr(sadc_pkg::OFS_PORT_REF, 32'(k * 17 & 32'h3f));
            wr(sadc_pkg::OFS_CONTROL_MAIN, 32'(k * 4 + 1));
            #1;
            check(analog_in_en, k == 0 ? 16'hffff : 16'hffff >> (k + 1));
            check(mux_channel, k);
            check(vref_neg_ext, k % 4 / 2);
            check(vref_pos_ext, k % 2);
        end
        for (int c = 0; c < 8; c++)
            conv(c, 0, 1'b0, c == 3);
        for (int a = 1; a < 8; a++)
            conv(4, a, 1'b0, 1'b0);
        conv(6, 0, 1'b1, 1'b0);
        conv(1, 0, 1'b0, 1'b1);
        wr(sadc_pkg::OFS_CONTROL_MAIN, 32'h07);
        repeat (3) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_resets;
        give_verdict;
    end
endmodule

bind sadc_sequencer sadc_checker #(.NUM_INPUTS(NUM_INPUTS)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_req(sleep_req), .cmp_high(cmp_high), .mux_channel(mux_channel),
    .sample_on(sample_on), .dac_code(dac_code), .calibrate_on(calibrate_on), .vref_neg_ext(vref_neg_ext),
    .vref_pos_ext(vref_pos_ext), .analog_in_en(analog_in_en), .conversion_done_flag(conversion_done_flag));
